// [pkg/pllcg_pkg.sv]
package pllcg_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [7:0] PLLCG_CTRL_OFS  = 8'h00;
  localparam logic [7:0] PLLCG_BW_OFS    = 8'h04;
  localparam logic [7:0] PLLCG_PROG_OFS  = 8'h08;
  localparam logic [7:0] PLLCG_BRK_OFS   = 8'h0C;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int CTRL_IE_BIT   = 7;
  localparam int CTRL_FLAG_BIT = 6;
  localparam int CTRL_EN_BIT   = 5;
  localparam int CTRL_SEL_BIT  = 4;
  localparam int BW_AUTO_BIT   = 7;
  localparam int BW_LOCK_BIT   = 6;
  localparam int BW_TRK_BIT    = 5;
  localparam int BRK_CLREN_BIT = 7;
  localparam int PROG_RATIO_HI = 7;
  localparam int PROG_RATIO_LO = 4;
  localparam int PROG_RANGE_HI = 3;
  localparam int PROG_RANGE_LO = 0;

  // ***************************************************
  // reset values and fixed patterns
  // ***************************************************
  localparam logic [3:0] RATIO_RESET     = 4'h6;
  localparam logic [3:0] RANGE_RESET     = 4'h6;
  localparam logic [3:0] NIBBLE_ZERO     = 4'h0;
  localparam logic [3:0] RATIO_ONE       = 4'h1;
  localparam logic [3:0] CTRL_UNUSED_RD  = 4'hF;
  localparam int         SWITCH_EDGES_DEF = 3;

  // ***************************************************
  // carriers
  // ***************************************************
  typedef struct packed {
    logic lock_window;   // error below lock entry tolerance
    logic track_window;  // error below tracking entry tolerance
  } pllcg_detect_t;

  typedef struct packed {
    logic stop_mode;
    logic wait_mode;
    logic break_state;
  } pllcg_mode_t;

  typedef enum logic [0:0] {
    CK_RUN,
    CK_SWITCH
  } pllcg_sel_state_t;

endpackage : pllcg_pkg

// [core/pllcg_top.sv]
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
module pllcg_top
  import pllcg_pkg::*;
#(
  parameter int SWITCH_EDGES = SWITCH_EDGES_DEF
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // source clocks, sampled as plain inputs
  input  wire logic          crystal_clock,
  input  wire logic          vco_clock,
  // analog loop and mode inputs
  input  wire pllcg_detect_t detect,
  input  wire pllcg_mode_t   mode,
  // outputs
  output logic               crystal_clock_out,
  output logic               base_clock_out,
  output logic               pll_irq,
  output logic               pll_active,
  output logic [3:0]         feedback_n,
  output logic [3:0]         vco_range
);

  // the switch counters are four bits wide
  if (SWITCH_EDGES < 1 || SWITCH_EDGES > 15) begin : g_bad_edges
    $error("SWITCH_EDGES out of range");
  end

  // ***************************************************
  // registers
  // ***************************************************
  logic             irq_enable_r;
  logic             pll_change_flag_r;
  logic             pll_enable_r;
  logic             base_clock_select_r;
  logic             auto_r;
  logic             manual_trk_r;
  logic             break_flag_clear_enable_r;
  logic [3:0]       feedback_ratio_r;
  logic [3:0]       range_r;
  logic             lock_r;
  logic             lock_q_r;
  logic             track_r;
  logic             rd_flag_r;
  logic             xtal_q_r;
  logic             vco_q_r;
  logic             active_src_r;
  logic [3:0]       xtal_cnt_r;
  logic [3:0]       vco_cnt_r;
  pllcg_sel_state_t sel_state_r;

  // ***************************************************
  // bus decode
  // ***************************************************
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_bw;
  logic hit_prog;
  logic hit_brk;
  logic mapped;
  logic range_zero;
  logic protect_flag;

  assign setup        = psel & ~penable;
  assign access       = psel & penable & pready;
  assign wr           = access & pwrite;
  assign rd           = access & ~pwrite;
  assign hit_ctrl     = (paddr == PLLCG_CTRL_OFS);
  assign hit_bw       = (paddr == PLLCG_BW_OFS);
  assign hit_prog     = (paddr == PLLCG_PROG_OFS);
  assign hit_brk      = (paddr == PLLCG_BRK_OFS);
  assign mapped       = hit_ctrl | hit_bw | hit_prog | hit_brk;
  assign range_zero   = (range_r == NIBBLE_ZERO);
  assign protect_flag = mode.break_state & ~break_flag_clear_enable_r;

  logic [7:0] ctrl_rd;
  logic [7:0] bw_rd;
  always_comb begin
    ctrl_rd = {irq_enable_r & auto_r,
               pll_change_flag_r & auto_r,
               pll_enable_r, base_clock_select_r, CTRL_UNUSED_RD};
    bw_rd   = {auto_r, lock_r, auto_r ? track_r : manual_trk_r, 5'h00};
  end

  // no wait state: answer registered at the setup edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      rd_flag_r <= 1'b0;
    end else begin
      pready    <= setup;
      pslverr   <= setup & ~mapped;
      rd_flag_r <= setup & ~pwrite & hit_ctrl & ctrl_rd[CTRL_FLAG_BIT];
      if (setup && !pwrite) begin
        prdata <= {24'h00_0000,
                   hit_ctrl ? ctrl_rd :
                   hit_bw   ? bw_rd :
                   hit_prog ? {feedback_ratio_r, range_r} :
                   hit_brk  ? {break_flag_clear_enable_r, 7'h00} : 8'h00};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ***************************************************
  // control register
  // ***************************************************
  // wait mode is deliberately not an input to any of this logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_enable_r <= 1'b0;
    end else if (wr && hit_ctrl && auto_r) begin
      irq_enable_r <= pwdata[CTRL_IE_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_clock_select_r <= 1'b0;
    end else if (mode.stop_mode || range_zero) begin
      base_clock_select_r <= 1'b0;
    end else if (wr && hit_ctrl) begin
      // lock is not consulted: software may select an unlocked vco
      if (pwdata[CTRL_SEL_BIT] && pll_enable_r) begin
        base_clock_select_r <= 1'b1;
      end else if (!pwdata[CTRL_SEL_BIT]) begin
        base_clock_select_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_enable_r <= 1'b1;
    end else if (wr && hit_ctrl && (pwdata[CTRL_EN_BIT] || !base_clock_select_r)) begin
      pll_enable_r <= pwdata[CTRL_EN_BIT];
    end
  end

  // set wins over the read clear; only a flag actually read is cleared
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_change_flag_r <= 1'b0;
    end else if (auto_r && (lock_r != lock_q_r)) begin
      pll_change_flag_r <= 1'b1;
    end else if (rd && hit_ctrl && rd_flag_r && !protect_flag) begin
      pll_change_flag_r <= 1'b0;
    end
  end

  // ***************************************************
  // bandwidth, program and break registers
  // ***************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      auto_r <= 1'b0;
    end else if (wr && hit_bw) begin
      auto_r <= pwdata[BW_AUTO_BIT];
    end
  end

  // in auto mode the manual value stays parked for later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      manual_trk_r <= 1'b0;
    end else if (wr && hit_bw && !auto_r) begin
      manual_trk_r <= pwdata[BW_TRK_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      feedback_ratio_r <= RATIO_RESET;
    end else if (wr && hit_prog && !pll_enable_r) begin
      feedback_ratio_r <= pwdata[PROG_RATIO_HI:PROG_RATIO_LO];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      range_r <= RANGE_RESET;
    end else if (wr && hit_prog && !pll_enable_r) begin
      range_r <= pwdata[PROG_RANGE_HI:PROG_RANGE_LO];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      break_flag_clear_enable_r <= 1'b0;
    end else if (wr && hit_brk) begin
      break_flag_clear_enable_r <= pwdata[BRK_CLREN_BIT];
    end
  end

  // ***************************************************
  // lock and tracking status
  // ***************************************************
  logic loop_on;
  assign loop_on = pll_enable_r & ~range_zero & ~mode.stop_mode;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= auto_r & loop_on & detect.lock_window;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      track_r <= 1'b0;
    end else begin
      track_r <= auto_r & loop_on & detect.track_window;
    end
  end

  // previous lock value, so each transition is seen once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_q_r <= 1'b0;
    end else begin
      lock_q_r <= lock_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_irq <= 1'b0;
    end else begin
      pll_irq <= pll_change_flag_r & irq_enable_r & auto_r & ~mode.stop_mode;
    end
  end

  // ***************************************************
  // loop programming outputs
  // ***************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      feedback_n <= RATIO_RESET;
    end else begin
      feedback_n <= (feedback_ratio_r == NIBBLE_ZERO) ? RATIO_ONE : feedback_ratio_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vco_range <= RANGE_RESET;
    end else begin
      vco_range <= range_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_active <= 1'b0;
    end else begin
      pll_active <= loop_on;
    end
  end

  // ***************************************************
  // base clock selector
  // ***************************************************
  logic xtal_rise;
  logic vco_rise;
  logic src_rise;
  assign xtal_rise = crystal_clock & ~xtal_q_r;
  assign vco_rise  = vco_clock & ~vco_q_r;
  assign src_rise  = active_src_r ? vco_rise : xtal_rise;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xtal_q_r <= 1'b0;
    end else begin
      xtal_q_r <= crystal_clock;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vco_q_r <= 1'b0;
    end else begin
      vco_q_r <= vco_clock;
    end
  end

  // output frozen until both sources have shown enough edges,
  // trading a short stall for a glitch-free handover
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_state_r  <= CK_RUN;
      active_src_r <= 1'b0;
      xtal_cnt_r   <= 4'h0;
      vco_cnt_r    <= 4'h0;
    end else begin
      case (sel_state_r)
        CK_RUN: begin
          xtal_cnt_r <= 4'h0;
          vco_cnt_r  <= 4'h0;
          if (base_clock_select_r != active_src_r) begin
            sel_state_r <= CK_SWITCH;
          end
        end
        CK_SWITCH: begin
          if (xtal_rise && xtal_cnt_r < 4'(SWITCH_EDGES)) begin
            xtal_cnt_r <= xtal_cnt_r + 4'h1;
          end
          if (vco_rise && vco_cnt_r < 4'(SWITCH_EDGES)) begin
            vco_cnt_r <= vco_cnt_r + 4'h1;
          end
          // a stop never waits on a vco that has gone quiet
          if (mode.stop_mode ||
              (xtal_cnt_r == 4'(SWITCH_EDGES) && vco_cnt_r == 4'(SWITCH_EDGES))) begin
            active_src_r <= base_clock_select_r;
            sel_state_r  <= CK_RUN;
          end
        end
        default: begin
          sel_state_r <= CK_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crystal_clock_out <= 1'b0;
    end else begin
      crystal_clock_out <= crystal_clock & ~mode.stop_mode;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_clock_out <= 1'b0;
    end else if (mode.stop_mode) begin
      base_clock_out <= 1'b0;
    end else if (sel_state_r == CK_RUN && src_rise) begin
      base_clock_out <= ~base_clock_out;
    end
  end

endmodule : pllcg_top

// [test/pllcg_top_asserts.sv]
`timescale 1ns/1ns
module pllcg_top_asserts
  import pllcg_pkg::*;
#(
  parameter int SWITCH_EDGES = SWITCH_EDGES_DEF
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          resetn,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // clocks, loop and mode
  input wire logic          crystal_clock,
  input wire logic          vco_clock,
  input wire pllcg_detect_t detect,
  input wire pllcg_mode_t   mode,
  // outputs
  input wire logic          crystal_clock_out,
  input wire logic          base_clock_out,
  input wire logic          pll_irq,
  input wire logic          pll_active,
  input wire logic [3:0]    feedback_n,
  input wire logic [3:0]    vco_range
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_setup;  psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  sequence s_done;    psel && penable && pready; endsequence
  sequence s_rd_done; s_done and (!pwrite); endsequence
  sequence s_wr_prog; s_done and (pwrite && paddr == PLLCG_PROG_OFS && pll_active); endsequence
  a_pready_once: assert property (s_setup |=> s_answer)
    else $error("pready not one cycle after setup");
  a_err_map: assert property (s_done |-> pslverr == (paddr[1:0] != 2'h0 || paddr > PLLCG_BRK_OFS))
    else $error("pslverr does not match the map");
  a_rd_upper: assert property (s_rd_done |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_ctrl_ones: assert property (s_rd_done ##0 (paddr == PLLCG_CTRL_OFS) |-> prdata[3:0] == CTRL_UNUSED_RD)
    else $error("control low nibble not ones");
  a_ratio_nonzero: assert property (feedback_n != NIBBLE_ZERO)
    else $error("multiplier zero");
  a_prog_outs: assert property (s_rd_done ##0 (paddr == PLLCG_PROG_OFS) |->
    vco_range == prdata[3:0] && feedback_n == ((prdata[7:4] == NIBBLE_ZERO) ? RATIO_ONE : prdata[7:4]))
    else $error("program outputs disagree with register");
  a_prog_locked: assert property (s_wr_prog |=> ($stable(vco_range) && $stable(feedback_n)) [*2])
    else $error("program register written while enabled");
  a_range_off: assert property (vco_range == NIBBLE_ZERO && $past(vco_range) == NIBBLE_ZERO |-> !pll_active)
    else $error("pll active with range zero");
  a_stop_low: assert property (mode.stop_mode |=> !crystal_clock_out && !base_clock_out && !pll_irq)
    else $error("outputs not low in stop");
  a_xtal_copy: assert property ($past(resetn) && !mode.stop_mode && !$past(mode.stop_mode)
    |-> crystal_clock_out == $past(crystal_clock))
    else $error("crystal output does not follow");
endmodule : pllcg_top_asserts

bind pllcg_top pllcg_top_asserts #(.SWITCH_EDGES(SWITCH_EDGES)) u_chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .crystal_clock(crystal_clock), .vco_clock(vco_clock), .detect(detect), .mode(mode),
  .crystal_clock_out(crystal_clock_out), .base_clock_out(base_clock_out), .pll_irq(pll_irq),
  .pll_active(pll_active), .feedback_n(feedback_n), .vco_range(vco_range));

// [test/pllcg_tb_top.sv]
`timescale 1ns/1ns
module pllcg_tb_top;
  import pllcg_pkg::*;
  logic          clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]    paddr = 8'h00, v;
  logic [31:0]   pwdata = 32'h0, prdata, seed = 32'h32;
  logic          pready, pslverr, xout, bout, pll_irq, pll_active;
  logic          crystal_clock = 0, vco_clock = 0;
  pllcg_detect_t detect = '0;
  pllcg_mode_t   mode = '0;
  logic [3:0]    feedback_n, vco_range;
  logic [32:0]   exp_q[$];
  int            bad_count = 0, num_checks = 0, cycles = 0;

  pllcg_top u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .detect(detect), .mode(mode), .crystal_clock_out(xout), .base_clock_out(bout),
    .pll_irq(pll_irq), .pll_active(pll_active), .feedback_n(feedback_n), .vco_range(vco_range));

  // ****
  // clocks, timeout and read monitor
  // ****
  always #4 clk = ~clk;
  // sources kept well below half the bus clock so every edge is sampled
  always @(posedge clk) begin
    cycles++;
    if (cycles % 3 == 0) crystal_clock <= ~crystal_clock;
    if (cycles % 2 == 0) vco_clock <= ~vco_clock;
    if (cycles > 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk("stray read", 33'h0, 33'h1);
      else chk("prdata", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ****
  // tasks
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err = 1'b0);
    exp_q.push_back({err, 24'h0, e});
    apb(1'b0, a, 8'h00);
  endtask : rd
  task automatic meas(input int want);
    int t;
    logic p;
    t = 0;
    p = bout;
    repeat (48) begin
      @(posedge clk);
      if (bout !== p) t++;
      p = bout;
    end
    chk("base_toggles", 33'(t >= want - 1 && t <= want + 1), 33'h1);
  endtask : meas
  task automatic lockin(input pllcg_detect_t d);
    @(posedge clk);
    detect <= d;
    repeat (6) @(posedge clk);
  endtask : lockin
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // ****
  // sequence
  // ****
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(PLLCG_PROG_OFS, 8'h66);
    rd(PLLCG_CTRL_OFS, 8'h2F);
    rd(8'h10, 8'h00, 1'b1);
    chk("feedback_n", feedback_n, 33'h6);
    chk("vco_range", vco_range, 33'h6);
    apb(1'b1, PLLCG_PROG_OFS, 8'h13);
    rd(PLLCG_PROG_OFS, 8'h66);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h00);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      v = {i[3:0], 4'(seed % 15 + 1)};
      apb(1'b1, PLLCG_PROG_OFS, v);
      rd(PLLCG_PROG_OFS, v);
      chk("feedback_n", feedback_n, (i == 0) ? 33'h1 : 33'(i));
      chk("vco_range", vco_range, 33'(v[3:0]));
    end
    $display("test program register done");
    apb(1'b1, PLLCG_PROG_OFS, 8'h40);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h20);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h30);
    rd(PLLCG_CTRL_OFS, 8'h2F);
    chk("pll_active", pll_active, 33'h0);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h00);
    apb(1'b1, PLLCG_PROG_OFS, 8'h46);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h10);
    rd(PLLCG_CTRL_OFS, 8'h0F);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h20);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h30);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h10);
    rd(PLLCG_CTRL_OFS, 8'h3F);
    repeat (20) @(posedge clk);
    meas(12);
    mode.stop_mode <= 1'b1;
    repeat (4) @(posedge clk);
    chk("stop_outs", {xout, bout, pll_irq, pll_active}, 33'h0);
    mode <= '{stop_mode: 1'b0, wait_mode: 1'b1, break_state: 1'b0};
    rd(PLLCG_CTRL_OFS, 8'h2F);
    repeat (20) @(posedge clk);
    meas(8);
    $display("test clock select done");
    apb(1'b1, PLLCG_BW_OFS, 8'h80);
    apb(1'b1, PLLCG_CTRL_OFS, 8'hA0);
    lockin(2'b01);
    rd(PLLCG_BW_OFS, 8'hA0);
    lockin(2'b11);
    chk("pll_irq", pll_irq, 33'h1);
    rd(PLLCG_BW_OFS, 8'hE0);
    rd(PLLCG_CTRL_OFS, 8'hEF);
    rd(PLLCG_CTRL_OFS, 8'hAF);
    apb(1'b1, PLLCG_CTRL_OFS, 8'h20);
    lockin(2'b00);
    chk("pll_irq", pll_irq, 33'h0);
    mode.break_state <= 1'b1;
    rd(PLLCG_CTRL_OFS, 8'h6F);
    rd(PLLCG_CTRL_OFS, 8'h6F);
    apb(1'b1, PLLCG_BRK_OFS, 8'h80);
    rd(PLLCG_CTRL_OFS, 8'h6F);
    mode.break_state <= 1'b0;
    rd(PLLCG_CTRL_OFS, 8'h2F);
    apb(1'b1, PLLCG_CTRL_OFS, 8'hA0);
    lockin(2'b11);
    chk("pll_irq", pll_irq, 33'h1);
    rd(PLLCG_BW_OFS, 8'hE0);
    apb(1'b1, PLLCG_CTRL_OFS, 8'hB0);
    apb(1'b1, PLLCG_BW_OFS, 8'h00);
    rd(PLLCG_CTRL_OFS, 8'h3F);
    chk("pll_irq", pll_irq, 33'h0);
    $display("test lock flag done");
    end_of_test();
  end
endmodule : pllcg_tb_top
